// file: drcd_pkg.sv
// package: constants and types for the context/directory entry check block
package drcd_pkg;
  // context entry low qword field positions
  localparam int CTX_PRESENT_BIT    = 0;
  localparam int CTX_FPD_BIT        = 1;
  localparam int CTX_DCE_BIT        = 2;
  localparam int CTX_TRE_BIT        = 3;
  localparam int CTX_DIRSZ_LSB      = 9;
  localparam int CTX_DIRSZ_MSB      = 11;
  localparam int CTX_DIRPTR_LSB     = 12;
  localparam int CTX_DIRPTR_MSB     = 63;
  // context entry second qword: requester-to-tag value, bits 83:64
  localparam int CTX_RTT_LSB        = 64;
  localparam int CTX_RTT_MSB        = 83;
  localparam int CTX_WIDTH          = 128;
  // directory entry field positions
  localparam int DIR_PRESENT_BIT    = 0;
  localparam int DIR_FPD_BIT        = 1;
  localparam int DIR_RSV_LSB        = 2;
  localparam int DIR_RSV_MSB        = 11;
  localparam int DIR_PTR_LSB        = 12;
  localparam int DIR_PTR_MSB        = 63;
  localparam int DIR_WIDTH          = 64;
  localparam int DIR_SIZE_BIAS      = 7;
  localparam int TAG_WIDTH          = 20;
  localparam int ADDR_WIDTH         = 64;
  localparam int HOST_ADDR_WIDTH    = 48;
  // register map
  localparam logic [3:0] REG_CONFIG_OFF = 4'h0;
  localparam logic [3:0] REG_STATUS_OFF = 4'h1;
  localparam logic [3:0] REG_MASK_OFF   = 4'h2;
  localparam logic [3:0] REG_RESULT_OFF = 4'h3;
  localparam logic [3:0] REG_COUNT_OFF  = 4'h4;
  localparam logic [31:0] CONFIG_RESET  = 32'h00000000;
  localparam logic [3:0]  STATUS_RESET  = 4'h0;
  localparam logic [3:0]  MASK_RESET    = 4'h0;
  // status bits
  localparam int ST_BLOCK  = 0;
  localparam int ST_FAULT  = 1;
  localparam int ST_SUPPR  = 2;
  localparam int ST_RSVD   = 3;

  typedef enum logic [1:0] {
    REQ_UNTRANSLATED = 2'b00,
    REQ_TRANSLATION  = 2'b01,
    REQ_TRANSLATED   = 2'b10
  } drcd_req_t;

  typedef enum logic [1:0] {
    VERDICT_BLOCK  = 2'b00,
    VERDICT_WALK   = 2'b01,
    VERDICT_BYPASS = 2'b10
  } drcd_verdict_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIR  = 2'b01,
    ST_DONE = 2'b10
  } drcd_state_t;
endpackage

// file: drcd_check.sv
// context and directory entry check with register port and interrupt
`timescale 1ns/1ps
module drcd_check
  import drcd_pkg::*;
(
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   clk_en,
  // register port
  input  wire logic [3:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  // request in
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire logic                   req_has_tag,
  input  wire logic [TAG_WIDTH-1:0]   req_tag,
  input  wire logic [1:0]             req_kind,
  input  wire logic [CTX_WIDTH-1:0]   ctx_entry,
  // directory entry fetch
  output logic                        dir_fetch,
  output logic      [ADDR_WIDTH-1:0]  dir_fetch_addr,
  input  wire logic                   dir_valid,
  input  wire logic [DIR_WIDTH-1:0]   dir_entry,
  // verdict out
  output logic                        res_valid,
  output logic      [1:0]             res_verdict,
  output logic                        res_fail,
  output logic                        res_fault,
  output logic      [TAG_WIDTH-1:0]   res_tag,
  output logic      [ADDR_WIDTH-1:0]  res_table_base,
  output logic      [31:0]            res_dir_entries,
  // interrupt
  output logic                        irq
);

  typedef struct packed {
    drcd_state_t              state;
    logic [31:0]              config_r;
    logic [3:0]               status;
    logic [3:0]               mask;
    logic [31:0]              count;
    logic [31:0]              rdata;
    logic                     fetch;
    logic [ADDR_WIDTH-1:0]    fetch_addr;
    logic                     ctx_fpd;
    logic                     has_tag;
    logic [TAG_WIDTH-1:0]     tag;
    logic [1:0]               kind;
    logic [31:0]              dir_entries;
    logic                     vld;
    logic [1:0]               verdict;
    logic                     fail;
    logic                     fault;
    logic [TAG_WIDTH-1:0]     otag;
    logic [ADDR_WIDTH-1:0]    base;
    logic [31:0]              oentries;
  } drcd_state_s_t;

  drcd_state_s_t s_reg;
  drcd_state_s_t s_next;

  // config bits: 0 tag support, 1 cache support, 2 requester-to-tag support
  logic                  tag_sup;
  logic                  cache_sup;
  logic                  rtt_sup;
  logic                  c_present;
  logic                  c_fpd;
  logic                  c_tre;
  logic                  c_dce;
  logic [2:0]            c_dirsz;
  logic [ADDR_WIDTH-1:0] c_dirptr;
  logic [ADDR_WIDTH-1:0] host_mask;
  logic                  eff_tagged;
  logic [TAG_WIDTH-1:0]  eff_tag;
  logic                  blk;
  logic                  bypass;
  logic [3:0]            ev;
  logic [ADDR_WIDTH-1:0] d_base;
  logic                  d_rsv_bad;

  always_comb begin
    tag_sup   = s_reg.config_r[0];
    cache_sup = s_reg.config_r[1];
    rtt_sup   = s_reg.config_r[2];
    host_mask = (64'h1 << HOST_ADDR_WIDTH) - 64'h1;
    c_present = ctx_entry[CTX_PRESENT_BIT];
    c_fpd     = ctx_entry[CTX_FPD_BIT];
    // unsupported fields read as zero; absent entry ignores them too
    c_tre     = c_present & tag_sup & ctx_entry[CTX_TRE_BIT];
    c_dce     = c_present & cache_sup & ctx_entry[CTX_DCE_BIT];
    c_dirsz   = ctx_entry[CTX_DIRSZ_MSB:CTX_DIRSZ_LSB];
    c_dirptr  = {ctx_entry[CTX_DIRPTR_MSB:CTX_DIRPTR_LSB], 12'h000} & host_mask;
    // untagged requests take the entry's tag, or zero when unsupported
    eff_tagged = req_has_tag | (rtt_sup & ~req_has_tag);
    eff_tag    = req_has_tag ? req_tag :
                 (rtt_sup ? ctx_entry[CTX_RTT_MSB:CTX_RTT_LSB] : '0);
    bypass = 1'b0;
    if (!c_present) begin
      blk = 1'b1;
    end else if (req_kind == REQ_TRANSLATED) begin
      blk    = ~c_dce;
      bypass = c_dce;
    end else if (req_kind == REQ_TRANSLATION && !c_dce) begin
      blk = 1'b1;
    end else if (req_has_tag) begin
      blk = ~c_tre;
    end else begin
      blk = 1'b0;
    end
    // directory pointer: bits 63:12 with host-width truncation, always physical
    d_base    = {dir_entry[DIR_PTR_MSB:DIR_PTR_LSB], 12'h000} & host_mask;
    d_rsv_bad = |dir_entry[DIR_RSV_MSB:DIR_RSV_LSB] |
                |({dir_entry[DIR_PTR_MSB:DIR_PTR_LSB], 12'h000} & ~host_mask);
  end

  always_comb begin
    s_next = s_reg;
    ev     = 4'h0;
    s_next.fetch = 1'b0;
    s_next.vld   = 1'b0;
    s_next.rdata = 32'h00000000;
    case (s_reg.state)
      ST_IDLE: begin
        if (req_valid) begin
          s_next.ctx_fpd = c_fpd;
          s_next.tag     = eff_tag;
          s_next.has_tag = eff_tagged;
          s_next.kind    = req_kind;
          s_next.dir_entries = 32'h1 << (32'(c_dirsz) + DIR_SIZE_BIAS);
          if (blk) begin
            s_next.vld     = 1'b1;
            s_next.verdict = VERDICT_BLOCK;
            s_next.fail    = 1'b1;
            s_next.fault   = ~c_fpd;
            s_next.otag    = eff_tag;
            s_next.base    = '0;
            s_next.oentries = 32'h0;
            ev[ST_BLOCK] = 1'b1;
            ev[ST_FAULT] = ~c_fpd;
            ev[ST_SUPPR] = c_fpd;
            s_next.count = s_reg.count + 32'h1;
          end else if (bypass) begin
            s_next.vld     = 1'b1;
            s_next.verdict = VERDICT_BYPASS;
            s_next.fail    = 1'b0;
            s_next.fault   = 1'b0;
            s_next.otag    = eff_tag;
            s_next.base    = '0;
            s_next.oentries = 32'h0;
          end else begin
            // walk: fetch the directory entry indexed by tag bits above the low 6
            s_next.fetch      = 1'b1;
            s_next.fetch_addr = c_dirptr +
                                {{(ADDR_WIDTH-TAG_WIDTH+3){1'b0}}, eff_tag[TAG_WIDTH-1:6], 3'b000};
            s_next.state = ST_DIR;
          end
        end
      end
      ST_DIR: begin
        if (dir_valid) begin
          s_next.vld  = 1'b1;
          s_next.otag = s_reg.tag;
          s_next.oentries = s_reg.dir_entries;
          s_next.state = ST_IDLE;
          if (!dir_entry[DIR_PRESENT_BIT] || d_rsv_bad) begin
            s_next.verdict = VERDICT_BLOCK;
            s_next.fail    = 1'b1;
            // context disable wins; otherwise the directory's own bit decides
            s_next.fault   = ~s_reg.ctx_fpd & ~dir_entry[DIR_FPD_BIT];
            s_next.base    = '0;
            ev[ST_BLOCK] = 1'b1;
            ev[ST_FAULT] = ~s_reg.ctx_fpd & ~dir_entry[DIR_FPD_BIT];
            ev[ST_SUPPR] = s_reg.ctx_fpd | dir_entry[DIR_FPD_BIT];
            ev[ST_RSVD]  = d_rsv_bad;
            s_next.count = s_reg.count + 32'h1;
          end else begin
            s_next.verdict = VERDICT_WALK;
            s_next.fail    = 1'b0;
            s_next.fault   = 1'b0;
            s_next.base    = d_base;
          end
        end
      end
      default: begin
        s_next.state = ST_IDLE;
      end
    endcase
    // register access; an event in the clearing read cycle survives
    if (reg_wr) begin
      case (reg_addr)
        REG_CONFIG_OFF: s_next.config_r = reg_wdata;
        REG_MASK_OFF:   s_next.mask     = reg_wdata[3:0];
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CONFIG_OFF: s_next.rdata = {29'h0, s_reg.config_r[2:0]};
        REG_STATUS_OFF: s_next.rdata = {28'h0, s_reg.status};
        REG_MASK_OFF:   s_next.rdata = {28'h0, s_reg.mask};
        REG_RESULT_OFF: s_next.rdata = {28'h0, s_reg.fault, s_reg.fail, s_reg.verdict};
        REG_COUNT_OFF:  s_next.rdata = s_reg.count;
        default:        s_next.rdata = 32'h00000000;
      endcase
    end
    if (reg_rd && reg_addr == REG_STATUS_OFF) begin
      s_next.status = ev;
    end else begin
      s_next.status = s_reg.status | ev;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg          <= '0;
      s_reg.state    <= ST_IDLE;
      s_reg.config_r <= CONFIG_RESET;
      s_reg.status   <= STATUS_RESET;
      s_reg.mask     <= MASK_RESET;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // ready is combinational: only idle accepts a new request
  assign req_ready       = (s_reg.state == ST_IDLE) & clk_en;
  assign reg_rdata       = s_reg.rdata;
  assign dir_fetch       = s_reg.fetch;
  assign dir_fetch_addr  = s_reg.fetch_addr;
  assign res_valid       = s_reg.vld;
  assign res_verdict     = s_reg.verdict;
  assign res_fail        = s_reg.fail;
  assign res_fault       = s_reg.fault;
  assign res_tag         = s_reg.otag;
  assign res_table_base  = s_reg.base;
  assign res_dir_entries = s_reg.oentries;
  assign irq             = |(s_reg.status & s_reg.mask);
endmodule

// file: drcd_check_sva.sv
// checker: verdict, fetch and fault relations at the entry-check ports
`timescale 1ns/1ps
module drcd_check_sva
  import drcd_pkg::*;
(
  // clock and reset
  input wire logic                  clock,
  input wire logic                  rst,
  // request and directory
  input wire logic                  req_valid,
  input wire logic                  req_ready,
  input wire logic                  req_has_tag,
  input wire logic [1:0]            req_kind,
  input wire logic [CTX_WIDTH-1:0]  ctx_entry,
  input wire logic                  dir_fetch,
  input wire logic                  dir_valid,
  input wire logic [DIR_WIDTH-1:0]  dir_entry,
  // verdict
  input wire logic                  res_valid,
  input wire logic [1:0]            res_verdict,
  input wire logic                  res_fail,
  input wire logic                  res_fault,
  input wire logic [ADDR_WIDTH-1:0] res_table_base
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire logic take = req_valid && req_ready;
  // with clk_en high, ready only drops while a directory answer is awaited
  wire logic dresp = dir_valid && !req_ready;
  wire logic blk = res_valid && res_verdict == VERDICT_BLOCK && res_fail;
  wire logic dok = dir_entry[0] && dir_entry[63:48] == 16'h0000 && dir_entry[11:2] == 10'h000;
  // context fault disable as captured with the request, not as it stands later
  logic cfpd_q;
  always_ff @(posedge clock) begin
    if (take) begin
      cfpd_q <= ctx_entry[1];
    end
  end
  property p_tag; take && ctx_entry[0] && !ctx_entry[3] && req_has_tag |=> blk; endproperty
  a_tag: assert property (p_tag) else $error("tagged request not blocked");
  property p_xl; take && ctx_entry[0] && !ctx_entry[2] && req_kind != 2'b00 |=> blk; endproperty
  a_xl: assert property (p_xl) else $error("translation not blocked");
  property p_abs; take && !ctx_entry[0] |=> blk && res_fault != $past(ctx_entry[1]); endproperty
  a_abs: assert property (p_abs) else $error("absent context mishandled");
  property p_fetch; dir_fetch |-> !req_ready && $past(take); endproperty
  a_fetch: assert property (p_fetch) else $error("fetch without request");
  property p_dabs; dresp && !dir_entry[0] |=> blk; endproperty
  a_dabs: assert property (p_dabs) else $error("absent directory not blocked");
  property p_dfpd; dresp && !dir_entry[0] && !cfpd_q |=> res_fault != $past(dir_entry[1]);
  endproperty
  a_dfpd: assert property (p_dfpd) else $error("directory fault disable wrong");
  property p_cfpd; dresp && cfpd_q |=> res_valid && !res_fault; endproperty
  a_cfpd: assert property (p_cfpd) else $error("context fault disable ignored");
  property p_walk; dresp && dok |=> res_valid && res_verdict == VERDICT_WALK && !res_fail
    && res_table_base == {$past(dir_entry[63:12]), 12'h000}; endproperty
  a_walk: assert property (p_walk) else $error("walk verdict or base wrong");
  property p_rsv; dresp && dir_entry[0] && dir_entry[63:48] != 16'h0000 |=> blk; endproperty
  a_rsv: assert property (p_rsv) else $error("high pointer bits accepted");
endmodule

// file: drcd_dir_model.sv
// partner: directory-entry memory answering the block's fetches after a set lag
`timescale 1ns/1ps
module drcd_dir_model
  import drcd_pkg::*;
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // fetch and answer
  input  wire logic                  dir_fetch,
  input  wire logic [ADDR_WIDTH-1:0] dir_fetch_addr,
  output logic                       dir_valid,
  output logic      [DIR_WIDTH-1:0]  dir_entry,
  // scenario control
  input  wire logic [DIR_WIDTH-1:0]  entry_val,
  input  wire logic [3:0]            lag,
  output logic      [ADDR_WIDTH-1:0] seen_addr
);
  logic [4:0] cnt;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 5'h00;
      dir_valid <= 1'b0;
      dir_entry <= 64'h0;
      seen_addr <= 64'h0;
    end else begin
      dir_valid <= 1'b0;
      // toggling outside answers so a stale entry never looks valid
      dir_entry <= ~dir_entry;
      if (dir_fetch) begin
        cnt <= {1'b0, lag} + 5'h01;
        seen_addr <= dir_fetch_addr;
      end else if (cnt == 5'h01) begin
        cnt <= 5'h00;
        dir_valid <= 1'b1;
        dir_entry <= entry_val;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule

// file: test_drcd_check.sv
// testbench: entry-check scenarios, register port and interrupt
`timescale 1ns/1ps
module test_drcd_check;
  import drcd_pkg::*;
  localparam logic [51:0] DPTR = 52'h0000123456789;
  localparam logic [63:0] DENT = 64'h0000ABCDEF012001;
  localparam logic [19:0] TAG = 20'hABCDE;
  logic clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0;
  logic req_has_tag = 1'b0, req_ready, dir_fetch, dir_valid, res_valid, res_fail, res_fault, irq;
  logic clk_en = 1'b1;
  logic [3:0] reg_addr = 4'h0, lag = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, res_dir_entries, rv;
  logic [19:0] req_tag = 20'h0, res_tag;
  logic [1:0] req_kind = 2'h0, res_verdict;
  logic [127:0] ctx_entry = 128'h0;
  logic [63:0] dir_entry, dir_fetch_addr, res_table_base, seen_addr, entry_val = DENT;
  int n_fail = 0, num_checks = 0, nblk = 0, cyc = 0;
  drcd_check u_drcd_check (.clock, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .req_valid, .req_ready, .req_has_tag, .req_tag, .req_kind, .ctx_entry, .dir_fetch,
    .dir_fetch_addr, .dir_valid, .dir_entry, .res_valid, .res_verdict, .res_fail, .res_fault,
    .res_tag, .res_table_base, .res_dir_entries, .irq);
  drcd_dir_model u_drcd_dir_model (.clock, .rst, .dir_fetch, .dir_fetch_addr, .dir_valid,
    .dir_entry, .entry_val, .lag, .seen_addr);
  initial begin
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      give_verdict();
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(posedge clock);
    rv = reg_rdata;
  endtask
  // one request held until taken, context held until its verdict, then verdict compared
  task automatic run(input logic t, input logic [1:0] k, input logic [3:0] low,
                     input logic [1:0] v, input logic f);
    int n;
    req_has_tag <= t;
    req_tag     <= TAG;
    req_kind    <= k;
    req_valid   <= 1'b1;
    ctx_entry   <= {44'h0, 20'h12345, DPTR, 3'h3, 5'h00, low};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < 20);
    req_valid <= 1'b0;
    // a wait that runs out counts as a mismatch, not a silent pass
    check({63'h0, req_ready}, 64'h1);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (res_valid !== 1'b1 && n < 20);
    check({63'h0, res_valid}, 64'h1);
    if (v == VERDICT_BLOCK) begin
      nblk++;
    end
    check({60'h0, res_verdict, res_fail, res_fault}, {60'h0, v, v == VERDICT_BLOCK, f});
  endtask
  task automatic t_tag();
    wr(REG_CONFIG_OFF, 32'h0);
    run(1'b1, REQ_UNTRANSLATED, 4'h9, VERDICT_BLOCK, 1'b1);
    wr(REG_CONFIG_OFF, 32'h7);
    run(1'b1, REQ_UNTRANSLATED, 4'h1, VERDICT_BLOCK, 1'b1);
    lag <= 4'h3;
    run(1'b1, REQ_UNTRANSLATED, 4'h9, VERDICT_WALK, 1'b0);
    check(seen_addr, {DPTR, 12'h000} + {47'h0, TAG[19:6], 3'h0});
    check(res_table_base, {DENT[63:12], 12'h000});
    check({32'h0, res_dir_entries}, 64'h400);
    lag <= 4'h0;
    run(1'b0, REQ_UNTRANSLATED, 4'h1, VERDICT_WALK, 1'b0);
    check({44'h0, res_tag}, 64'h12345);
  endtask
  task automatic t_cache();
    run(1'b0, REQ_TRANSLATED, 4'h1, VERDICT_BLOCK, 1'b1);
    run(1'b1, REQ_TRANSLATION, 4'h9, VERDICT_BLOCK, 1'b1);
    run(1'b0, REQ_TRANSLATED, 4'h5, VERDICT_BYPASS, 1'b0);
    run(1'b1, REQ_TRANSLATION, 4'hD, VERDICT_WALK, 1'b0);
    wr(REG_CONFIG_OFF, 32'h5);
    run(1'b0, REQ_TRANSLATED, 4'h5, VERDICT_BLOCK, 1'b1);
    wr(REG_CONFIG_OFF, 32'h7);
  endtask
  task automatic t_fault();
    run(1'b1, REQ_UNTRANSLATED, 4'hC, VERDICT_BLOCK, 1'b1);
    run(1'b1, REQ_UNTRANSLATED, 4'hE, VERDICT_BLOCK, 1'b0);
    run(1'b1, REQ_UNTRANSLATED, 4'h3, VERDICT_BLOCK, 1'b0);
    entry_val <= 64'h0;
    run(1'b1, REQ_UNTRANSLATED, 4'h9, VERDICT_BLOCK, 1'b1);
    run(1'b1, REQ_UNTRANSLATED, 4'hB, VERDICT_BLOCK, 1'b0);
    entry_val <= 64'h2;
    run(1'b1, REQ_UNTRANSLATED, 4'h9, VERDICT_BLOCK, 1'b0);
    entry_val <= DENT | 64'h0001000000000000;
    run(1'b1, REQ_UNTRANSLATED, 4'h9, VERDICT_BLOCK, 1'b1);
    entry_val <= DENT;
  endtask
  task automatic t_irq();
    // every event kind has happened by now: block, fault, suppressed, reserved
    rd(REG_STATUS_OFF);
    check({32'h0, rv}, 64'hF);
    wr(REG_MASK_OFF, 32'h1);
    run(1'b1, REQ_UNTRANSLATED, 4'h1, VERDICT_BLOCK, 1'b1);
    @(posedge clock);
    check({63'h0, irq}, 64'h1);
    rd(REG_STATUS_OFF);
    check({32'h0, rv}, 64'h3);
    check({63'h0, irq}, 64'h0);
    wr(REG_MASK_OFF, 32'h0);
    run(1'b1, REQ_UNTRANSLATED, 4'h1, VERDICT_BLOCK, 1'b1);
    check({63'h0, irq}, 64'h0);
    rd(REG_COUNT_OFF);
    check({32'h0, rv}, {32'h0, 32'(nblk)});
    rd(4'hF);
    check({32'h0, rv}, 64'h0);
    // a write while the enable is low must leave the mask untouched
    clk_en <= 1'b0;
    wr(REG_MASK_OFF, 32'h1);
    clk_en <= 1'b1;
    rd(REG_MASK_OFF);
    check({32'h0, rv}, 64'h0);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(REG_CONFIG_OFF);
    check({32'h0, rv}, {32'h0, CONFIG_RESET});
    t_tag();
    t_cache();
    t_fault();
    t_irq();
    give_verdict();
  end
endmodule
bind drcd_check drcd_check_sva u_drcd_check_sva (.clock, .rst, .req_valid, .req_ready,
  .req_has_tag, .req_kind, .ctx_entry, .dir_fetch, .dir_valid, .dir_entry, .res_valid,
  .res_verdict, .res_fail, .res_fault, .res_table_base);
